// *** src/rps_pkg.sv ***
package rps_pkg;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned IN_SEL_W   = 7;
    localparam int unsigned OUT_SEL_W  = 6;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned NUM_REGS   = 16;
    localparam int unsigned IDX_W      = 4;
    localparam int unsigned NUM_SRC    = 122;
    localparam int unsigned NUM_FUNC   = 64;
    localparam int unsigned NUM_IN     = 8;
    localparam int unsigned NUM_OUT    = 17;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SPI2_CD   = 4'h0;
    localparam logic [IDX_W-1:0] IDX_SPI2_SS   = 4'h1;
    localparam logic [IDX_W-1:0] IDX_CAN_RX    = 4'h2;
    localparam logic [IDX_W-1:0] IDX_PWM_SYNC  = 4'h3;
    localparam logic [IDX_W-1:0] IDX_DTC_ONE   = 4'h4;
    localparam logic [IDX_W-1:0] IDX_DTC_23    = 4'h5;
    localparam logic [IDX_W-1:0] IDX_OUT_FIRST = 4'h6;
    localparam logic [IDX_W-1:0] IDX_OUT_LAST  = 4'hf;

    // implemented-bit masks per register layout
    localparam logic [REG_W-1:0] MASK_IN_LO    = 16'h007f;
    localparam logic [REG_W-1:0] MASK_IN_HI    = 16'h7f00;
    localparam logic [REG_W-1:0] MASK_IN_BOTH  = 16'h7f7f;
    localparam logic [REG_W-1:0] MASK_OUT_LO   = 16'h003f;
    localparam logic [REG_W-1:0] MASK_OUT_HI   = 16'h3f00;
    localparam logic [REG_W-1:0] MASK_OUT_BOTH = 16'h3f3f;
    localparam logic [REG_W-1:0] REG_RESET     = 16'h0000;

    localparam int unsigned FLD_LO_POS = 0;
    localparam int unsigned FLD_HI_POS = 8;

    localparam logic [IN_SEL_W-1:0] SEL_GROUND = 7'h00;
    localparam logic [IN_SEL_W-1:0] SEL_COMPARATOR_ONE_OUTPUT   = 7'h01;
    localparam logic [IN_SEL_W-1:0] SEL_PIN121 = 7'h79;
endpackage

// *** src/rps_cfg_if.sv ***
`timescale 1ns/1ps
interface rps_cfg_if;
    import rps_pkg::*;
    logic [IN_SEL_W-1:0]  in_sel  [NUM_IN];
    logic [OUT_SEL_W-1:0] out_sel [NUM_OUT];
    modport regs (output in_sel, output out_sel);
    modport mux  (input in_sel, input out_sel);
endinterface

// *** src/rps_route.sv ***
`timescale 1ns/1ps
module rps_route
    import rps_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    rps_cfg_if.mux                    cfg,
    input  wire logic [NUM_SRC-1:0]   src,
    input  wire logic [NUM_FUNC-1:0]  func,
    output logic      [NUM_IN-1:0]    periph_in,
    output logic      [NUM_OUT-1:0]   pin_out
);
    // code 0 is the ground source, code 1 the comparator, top code pin 121
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_in <= '0;
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (cfg.in_sel[i] == SEL_GROUND) begin
                    periph_in[i] <= 1'b0;
                end else if (cfg.in_sel[i] > SEL_PIN121) begin
                    periph_in[i] <= 1'b0;
                end else begin
                    periph_in[i] <= src[cfg.in_sel[i]];
                end
            end
        end
    end

    // function 0 is "no peripheral", driving the pin output low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
        end else begin
            for (int j = 0; j < NUM_OUT; j++) begin
                if (cfg.out_sel[j] == '0) begin
                    pin_out[j] <= 1'b0;
                end else begin
                    pin_out[j] <= func[cfg.out_sel[j]];
                end
            end
        end
    end
endmodule

// *** src/rps_top.sv ***
// Overview of operation
// - each peripheral input select field is seven bits choosing pin or source
// - code zero ties the peripheral input to ground
// - top code selects input-only pin 121; middle codes select others
// - code one selects the first comparator output
// - each output select field is six bits choosing a peripheral function
// - bits without a field ignore writes and read as zero
// - serial data select in low bits, serial clock select in upper byte
// - paired output registers: one pin in bits 13-8, other in 5-0
// - last output register holds pin 120 select in its low six bits
`timescale 1ns/1ps
module rps_top
    import rps_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [rps_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [rps_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [rps_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [rps_pkg::NUM_SRC-1:0]  route_src,
    input  wire logic [rps_pkg::NUM_FUNC-1:0] route_func,
    output logic      [rps_pkg::NUM_IN-1:0]   periph_in,
    output logic      [rps_pkg::NUM_OUT-1:0]  pin_out
);
    import rps_pkg::*;

    logic [REG_W-1:0] regs_r [NUM_REGS];
    logic [IDX_W-1:0] idx;
    logic             mapped;
    logic             wr_en;
    logic [REG_W-1:0] wdata;

    rps_cfg_if cfg ();

    function automatic logic [REG_W-1:0] reg_mask(input logic [IDX_W-1:0] i);
        case (i)
            IDX_SPI2_CD:  reg_mask = MASK_IN_BOTH;
            IDX_SPI2_SS:  reg_mask = MASK_IN_LO;
            IDX_CAN_RX:   reg_mask = MASK_IN_LO;
            IDX_PWM_SYNC: reg_mask = MASK_IN_HI;
            IDX_DTC_ONE:  reg_mask = MASK_IN_HI;
            IDX_DTC_23:   reg_mask = MASK_IN_BOTH;
            4'hd:         reg_mask = MASK_OUT_HI;
            4'he:         reg_mask = MASK_OUT_HI;
            IDX_OUT_LAST: reg_mask = MASK_OUT_LO;
            default:      reg_mask = MASK_OUT_BOTH;
        endcase
    endfunction

    assign idx    = paddr[IDX_W+1:2];
    assign mapped = (paddr[ADDR_W-1:IDX_W+2] == '0)
                    && (paddr[1:0] == 2'h0);
    assign wr_en  = psel && penable && pwrite && mapped;
    assign wdata  = {pstrb[1] ? pwdata[15:8] : regs_r[idx][15:8],
                     pstrb[0] ? pwdata[7:0]  : regs_r[idx][7:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                regs_r[k] <= REG_RESET;
            end
        end else if (wr_en) begin
            regs_r[idx] <= wdata & reg_mask(idx);
        end
    end

    // zero-wait-state slave: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite && mapped) begin
                prdata <= {{(DATA_W-REG_W){1'b0}}, regs_r[idx]};
            end else begin
                prdata <= '0;
            end
        end
    end

    always_comb begin
        cfg.in_sel[0] = regs_r[IDX_SPI2_CD][FLD_HI_POS +: IN_SEL_W];
        cfg.in_sel[1] = regs_r[IDX_SPI2_CD][FLD_LO_POS +: IN_SEL_W];
        cfg.in_sel[2] = regs_r[IDX_SPI2_SS][FLD_LO_POS +: IN_SEL_W];
        cfg.in_sel[3] = regs_r[IDX_CAN_RX][FLD_LO_POS +: IN_SEL_W];
        cfg.in_sel[4] = regs_r[IDX_PWM_SYNC][FLD_HI_POS +: IN_SEL_W];
        cfg.in_sel[5] = regs_r[IDX_DTC_ONE][FLD_HI_POS +: IN_SEL_W];
        cfg.in_sel[6] = regs_r[IDX_DTC_23][FLD_LO_POS +: IN_SEL_W];
        cfg.in_sel[7] = regs_r[IDX_DTC_23][FLD_HI_POS +: IN_SEL_W];
        for (int p = 0; p < 7; p++) begin
            cfg.out_sel[2*p]   = regs_r[IDX_OUT_FIRST + 4'(p)]
                                 [FLD_LO_POS +: OUT_SEL_W];
            cfg.out_sel[2*p+1] = regs_r[IDX_OUT_FIRST + 4'(p)]
                                 [FLD_HI_POS +: OUT_SEL_W];
        end
        cfg.out_sel[14] = regs_r[4'hd][FLD_HI_POS +: OUT_SEL_W];
        cfg.out_sel[15] = regs_r[4'he][FLD_HI_POS +: OUT_SEL_W];
        cfg.out_sel[16] = regs_r[IDX_OUT_LAST][FLD_LO_POS +: OUT_SEL_W];
    end

    rps_route u_route (
        .pclk      (pclk),
        .presetn   (presetn),
        .cfg       (cfg),
        .src       (route_src),
        .func      (route_func),
        .periph_in (periph_in),
        .pin_out   (pin_out)
    );
endmodule

// *** verif/rps_top_asserts.sv ***
`timescale 1ns/1ps
module rps_top_asserts
    import rps_pkg::*;
(
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic [rps_pkg::ADDR_W-1:0]    paddr,
    input wire logic [rps_pkg::DATA_W-1:0]    prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic [rps_pkg::NUM_IN-1:0]    periph_in,
    input wire logic [rps_pkg::NUM_OUT-1:0]   pin_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup_c = psel && !penable;
    a_ready_first: assert property (setup_c |=> pready && penable)
        else $error("ready missing in first access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (setup_c && paddr >= 12'h040 |=> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property
        (setup_c && paddr < 12'h040 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_unimpl_zero:
        assert property (pready |-> prdata[31:15] == 0 && !prdata[7])
        else $error("unimplemented bits read nonzero");
    a_out_width:
        assert property (pready && paddr >= 12'h018 |-> !prdata[14] && !prdata[6])
        else $error("output field wider than six bits");
    a_reset_clear:
        assert property ($rose(presetn) |-> periph_in == 0 && pin_out == 0)
        else $error("routed outputs not clear after reset");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_last_layout:
        assert property (pready && paddr == 12'h03c |-> prdata[15:6] == 10'h0)
        else $error("last output register upper bits nonzero");
    cover property (pready && !pslverr);
    cover property (pslverr);
    cover property ($rose(periph_in[0]));
endmodule
bind rps_top rps_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_in(periph_in),
    .pin_out(pin_out));

// *** verif/rps_top_tb.sv ***
`timescale 1ns/1ps
module rps_top_tb;
    import rps_pkg::*;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, q;
    logic         pready, pslverr, e;
    logic [121:0] route_src = '0;
    logic [63:0]  route_func = '0;
    logic [7:0]   periph_in;
    logic [16:0]  pin_out;
    logic [3:0]   pstrb = '0, ps = 4'hf;
    int           fails = 0, checks = 0, i;
    localparam logic [15:0] MSK [16] = '{16'h7f7f, 16'h007f, 16'h007f,
        16'h7f00, 16'h7f00, 16'h7f7f, 16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f,
        16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f00, 16'h3f00, 16'h003f};
    always #20 pclk = ~pclk;
    rps_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .route_src(route_src), .route_func(route_func),
        .periph_in(periph_in), .pin_out(pin_out));
    task end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        pstrb <= w ? ps : 4'h0;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        if (n == 16) begin fails++; end_of_test(); end
    endtask
    // routed outputs follow one clock after a change; look mid-cycle,
    // then return on a rising edge so the next drive lands there
    task pins(input logic [7:0] ei, input logic [16:0] eo);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({24'h0, periph_in}, {24'h0, ei});
        chk({15'h0, pin_out}, {15'h0, eo});
        @(posedge pclk);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 16; i++) begin
            xfer(12'(i * 4), 0, 0); chk(q, 0);
        end
        $display("reset values done");
        for (i = 0; i < 16; i++) begin
            xfer(12'(i * 4), 1, '1); xfer(12'(i * 4), 0, 0);
            chk(q, {16'h0, MSK[i]});
        end
        xfer(12'h040, 1, '1); chk({31'h0, e}, 1);
        xfer(12'h002, 0, 0); chk({31'h0, e}, 1);
        chk(q, 0);
        $display("layout and refusal done");
        xfer(12'h000, 1, 32'h7901); route_src[1] <= 1;
        pins(8'h02, 17'h0);
        route_src <= {1'b1, 121'h0};
        pins(8'h01, 17'h0);
        route_src <= '1; xfer(12'h000, 1, 0);
        pins(8'h00, 17'h0);
        xfer(12'h004, 1, 32'h0002);
        xfer(12'h008, 1, 32'h0003);
        xfer(12'h00c, 1, 32'h0400);
        xfer(12'h010, 1, 32'h0500);
        xfer(12'h014, 1, 32'h0706);
        route_src <= 122'h0a8;
        pins(8'ha8, 17'h0);
        route_src <= 122'h054;
        pins(8'h54, 17'h0);
        route_src <= '0;
        xfer(12'h018, 1, 32'h0203); route_func <= 64'h8;
        pins(8'h00, 17'h00001);
        route_func <= 64'h4;
        pins(8'h00, 17'h00002);
        xfer(12'h030, 1, 32'h0102);
        pins(8'h00, 17'h01002);
        route_func <= 64'h2;
        pins(8'h00, 17'h02000);
        xfer(12'h03c, 1, 32'h003f); route_func <= {1'b1, 63'h0};
        pins(8'h00, 17'h1cffc);
        ps = 4'h1;
        xfer(12'h018, 1, 32'h1111);
        ps = 4'hf;
        xfer(12'h018, 0, 0);
        chk(q, 32'h0211);
        $display("routing done");
        @(posedge pclk);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        route_func <= '1;
        xfer(12'h018, 0, 0); chk(q, 0);
        pins(8'h00, 17'h0);
        $display("second reset done");
        end_of_test();
    end
endmodule
